/* hw/mppc_pkg.sv */
package mppc_pkg;
  localparam int unsigned         PIN_COUNT         = 12;
  localparam logic [7:0]          PIN_CFG_OFFSET    = 8'h04;
  localparam logic [7:0]          LOCAL_CFG_OFFSET  = 8'h00;
  localparam logic [7:0]          PM_STATUS_OFFSET  = 8'h10;
  localparam logic [31:0]         PIN_CFG_RESET     = 32'h0000_0000;
  localparam logic [31:0]         PIN_CFG_WMASK     = 32'h00FF_FFFF;
  localparam int unsigned         EVENT_EN_BIT      = 7;
  localparam int unsigned         EVENT_PIN         = 2;
  localparam int unsigned         EVENT_POL_BIT     = 4;
  localparam int unsigned         PM_STATUS_BIT     = 15;
  localparam int unsigned         PM_ENABLE_BIT     = 8;
  localparam logic [1:0]          MODE_PARALLEL     = 2'h1;
  localparam logic [1:0]          CFG_IN_PLAIN      = 2'h0;
  localparam logic [1:0]          CFG_IN_INVERT     = 2'h1;
  localparam logic [1:0]          CFG_OUT_LOW       = 2'h2;
  localparam logic [1:0]          CFG_OUT_HIGH      = 2'h3;
endpackage : mppc_pkg

/* hw/mppc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module mppc_top (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        CFG_WR,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [31:0] CFG_WDATA,
  output logic      [31:0] CFG_RDATA,
  input  wire logic [1:0]  DEVICE_MODE,
  input  wire logic [11:0] PIN_IN,
  output logic      [11:0] PIN_OUT,
  output logic      [11:0] PIN_OE,
  output logic      [11:0] PIN_LEVEL,
  output logic             POWER_EVENT_B
);
  logic [31:0] cfg_r, cfg_nxt;
  logic        evt_en_r, evt_en_nxt;
  logic        pm_stat_r, pm_stat_nxt;
  logic        pm_en_r, pm_en_nxt;
  logic [11:0] sync1_r, sync2_r;
  logic [11:0] lvl_r, lvl_nxt;
  logic [11:0] out_r, out_nxt, oe_r, oe_nxt;
  logic        evt_active;
  logic [31:0] rd_nxt, rd_r;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser, first stage read only by the second and by the a_sync check
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_r <= 12'h000;
      sync2_r <= 12'h000;
    end else begin
      sync1_r <= PIN_IN;
      sync2_r <= sync1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin configuration decode
  always_comb begin
    lvl_nxt = lvl_r;
    out_nxt = 12'h000;
    oe_nxt  = 12'h000;
    for (int i = 0; i < 12; i++) begin
      case (cfg_r[2*i +: 2])
        mppc_pkg::CFG_IN_PLAIN:  lvl_nxt[i] = sync2_r[i];
        mppc_pkg::CFG_IN_INVERT: lvl_nxt[i] = ~sync2_r[i];
        mppc_pkg::CFG_OUT_LOW: begin
          oe_nxt[i]  = 1'b1;
          out_nxt[i] = 1'b0;
          lvl_nxt[i] = 1'b0;
        end
        default: begin
          oe_nxt[i]  = 1'b1;
          out_nxt[i] = 1'b1;
          lvl_nxt[i] = 1'b1;
        end
      endcase
    end
    // Parallel port owns pin 0; hold it driven low so it never floats
    if (DEVICE_MODE == mppc_pkg::MODE_PARALLEL) begin
      oe_nxt[0]  = 1'b1;
      out_nxt[0] = 1'b0;
      lvl_nxt[0] = 1'b0;
    end
    if (evt_en_r) begin
      oe_nxt[mppc_pkg::EVENT_PIN]  = 1'b0;
      out_nxt[mppc_pkg::EVENT_PIN] = 1'b0;
      lvl_nxt[mppc_pkg::EVENT_PIN] = sync2_r[mppc_pkg::EVENT_PIN];
    end
  end

  // Polarity bit 1 means the event input is active low
  assign evt_active = evt_en_r &
    (sync2_r[mppc_pkg::EVENT_PIN] ^ cfg_r[mppc_pkg::EVENT_POL_BIT]);

  //////////////////////////////////////////////////////////////////////////////
  // Register writes and sticky status
  always_comb begin
    cfg_nxt     = cfg_r;
    evt_en_nxt  = evt_en_r;
    pm_en_nxt   = pm_en_r;
    pm_stat_nxt = pm_stat_r;
    if (CFG_WR && CFG_ADDR == mppc_pkg::PIN_CFG_OFFSET)
      cfg_nxt = CFG_WDATA & mppc_pkg::PIN_CFG_WMASK;
    if (CFG_WR && CFG_ADDR == mppc_pkg::LOCAL_CFG_OFFSET)
      evt_en_nxt = CFG_WDATA[mppc_pkg::EVENT_EN_BIT];
    if (CFG_WR && CFG_ADDR == mppc_pkg::PM_STATUS_OFFSET) begin
      pm_en_nxt = CFG_WDATA[mppc_pkg::PM_ENABLE_BIT];
      if (CFG_WDATA[mppc_pkg::PM_STATUS_BIT])
        pm_stat_nxt = 1'b0; // Write one to clear
    end
    // Set wins over a clear in the same cycle
    if (evt_active)
      pm_stat_nxt = 1'b1;
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (CFG_ADDR)
      mppc_pkg::PIN_CFG_OFFSET:   rd_nxt = cfg_r;
      mppc_pkg::LOCAL_CFG_OFFSET: rd_nxt[mppc_pkg::EVENT_EN_BIT] = evt_en_r;
      mppc_pkg::PM_STATUS_OFFSET: begin
        rd_nxt[mppc_pkg::PM_STATUS_BIT] = pm_stat_r;
        rd_nxt[mppc_pkg::PM_ENABLE_BIT] = pm_en_r;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_r     <= mppc_pkg::PIN_CFG_RESET;
      evt_en_r  <= 1'b0;
      pm_en_r   <= 1'b0;
      pm_stat_r <= 1'b0;
      lvl_r     <= 12'h000;
      out_r     <= 12'h000;
      oe_r      <= 12'h000;
      rd_r      <= 32'h0000_0000;
    end else begin
      cfg_r     <= cfg_nxt;
      evt_en_r  <= evt_en_nxt;
      pm_en_r   <= pm_en_nxt;
      pm_stat_r <= pm_stat_nxt;
      lvl_r     <= lvl_nxt;
      out_r     <= out_nxt;
      oe_r      <= oe_nxt;
      rd_r      <= rd_nxt;
    end
  end

  assign PIN_OUT       = out_r;
  assign PIN_OE        = oe_r;
  assign PIN_LEVEL     = lvl_r;
  assign CFG_RDATA     = rd_r;
  assign POWER_EVENT_B = ~(pm_stat_r & pm_en_r);

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_cfg_write(logic [1:0] code);
    CFG_WR && CFG_ADDR == mppc_pkg::PIN_CFG_OFFSET && CFG_WDATA[7:6] == code;
  endsequence

  property p_field_map;
    @(posedge CLK) disable iff (!RST_B)
    CFG_WR && CFG_ADDR == mppc_pkg::PIN_CFG_OFFSET |=> cfg_r[23:0] == $past(CFG_WDATA[23:0]);
  endproperty
  a_field_map: assert property (p_field_map) else $error("config field not stored");

  property p_reserved;
    @(posedge CLK) disable iff (!RST_B)
    cfg_r[31:24] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved config bits set");

  property p_invert;
    @(posedge CLK) disable iff (!RST_B)
    cfg_r[7:6] == mppc_pkg::CFG_IN_INVERT && $stable(cfg_r) |=> lvl_r[3] == !$past(sync2_r[3]);
  endproperty
  a_invert: assert property (p_invert) else $error("inverted input wrong");

  property p_out_high;
    @(posedge CLK) disable iff (!RST_B)
    s_cfg_write(mppc_pkg::CFG_OUT_HIGH) |=> ##1 (oe_r[3] && out_r[3]);
  endproperty
  a_out_high: assert property (p_out_high) else $error("pin 3 not driven high");

  property p_out_low;
    @(posedge CLK) disable iff (!RST_B)
    s_cfg_write(mppc_pkg::CFG_OUT_LOW) |=> ##1 (oe_r[3] && !out_r[3]);
  endproperty
  a_out_low: assert property (p_out_low) else $error("pin 3 not driven low");

  property p_parallel;
    @(posedge CLK) disable iff (!RST_B)
    DEVICE_MODE == mppc_pkg::MODE_PARALLEL |=> oe_r[0] && !out_r[0];
  endproperty
  a_parallel: assert property (p_parallel) else $error("pin 0 not forced");

  property p_event_input;
    @(posedge CLK) disable iff (!RST_B)
    evt_en_r |=> !oe_r[mppc_pkg::EVENT_PIN];
  endproperty
  a_event_input: assert property (p_event_input) else $error("pin 2 still driven");

  property p_polarity;
    @(posedge CLK) disable iff (!RST_B)
    evt_en_r && sync2_r[2] != cfg_r[4] |=> pm_stat_r;
  endproperty
  a_polarity: assert property (p_polarity) else $error("event polarity wrong");

  property p_sticky;
    @(posedge CLK) disable iff (!RST_B)
    pm_stat_r && !(CFG_WR && CFG_ADDR == mppc_pkg::PM_STATUS_OFFSET) |=> pm_stat_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost");

  property p_gate;
    @(posedge CLK) disable iff (!RST_B)
    !pm_stat_r && !evt_en_r |=> !pm_stat_r;
  endproperty
  a_gate: assert property (p_gate) else $error("status set while disabled");

  property p_event_pin;
    @(posedge CLK) disable iff (!RST_B)
    pm_stat_r && pm_en_r |-> !POWER_EVENT_B;
  endproperty
  a_event_pin: assert property (p_event_pin) else $error("event pin not asserted");

  property p_event_quiet;
    @(posedge CLK) disable iff (!RST_B)
    !pm_en_r |-> POWER_EVENT_B;
  endproperty
  a_event_quiet: assert property (p_event_quiet) else $error("event pin active while off");

  property p_sync;
    @(posedge CLK) disable iff (!RST_B)
    cfg_r[1:0] == 2'h0 && DEVICE_MODE != mppc_pkg::MODE_PARALLEL
      |=> lvl_r[0] == $past(sync1_r[0], 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync depth wrong");
endmodule : mppc_top
`default_nettype wire

/* test/mppc_board.sv */
`timescale 1ns/1ps
`default_nettype none
module mppc_board (
  input  wire logic [11:0] pin_out,
  input  wire logic [11:0] pin_oe,
  input  wire logic [11:0] ext_level,
  output logic      [11:0] pin_in
);
  // Board logic drives only the pins the device leaves free
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : mppc_board
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, rst_b, wr, event_b;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [1:0]  mode;
  logic [11:0] pin_in, pin_out, pin_oe, pin_level, ext;
  int          n_errors, checks, seed;
  logic [2:0]  sel_q[$];
  logic [31:0] exp_q[$];
  string       nm[5] = '{"rdata", "oe", "out", "level", "event_b"};
  event        seen;
  mppc_top mppc_top_inst (.CLK(clk), .RST_B(rst_b), .CFG_WR(wr), .CFG_ADDR(addr),
    .CFG_WDATA(wdata), .CFG_RDATA(rdata), .DEVICE_MODE(mode), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_LEVEL(pin_level), .POWER_EVENT_B(event_b));
  mppc_board mppc_board_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
    .pin_in(pin_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic compare(input string what, input logic [31:0] got, input logic [31:0] e);
    checks++;
    if (got !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask : compare
  // Drains every pending note, as several may be posted in one step
  always @(seen) begin
    logic [31:0] obs [5];
    logic [2:0]  s;
    obs = '{rdata, {20'h0, pin_oe}, {20'h0, pin_out}, {20'h0, pin_level}, {31'h0, event_b}};
    while (sel_q.size() > 0) begin
      // Pop first so the name and the value come from the same note
      s = sel_q.pop_front();
      compare(nm[s], obs[s], exp_q.pop_front());
    end
  end
  task automatic note(input logic [2:0] s, input logic [31:0] e);
    sel_q.push_back(s);
    exp_q.push_back(e);
    -> seen;
  endtask : note
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    addr = a;
    @(negedge clk);
    note(3'h0, e);
  endtask : rd_reg
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    n_errors++;
    conclude();
  end
  initial begin
    seed = 19104;
    {wr, addr, wdata, mode, ext, rst_b, n_errors, checks} = '0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    rd_reg(8'h04, 32'h0000_0000);
    wr_reg(8'h04, 32'hFFFF_FFFF);
    rd_reg(8'h04, 32'h00FF_FFFF);
    for (int c = 0; c < 4; c++) begin
      ext = 12'($random(seed));
      wr_reg(8'h04, {8'h00, {12{c[1:0]}}});
      repeat (4) @(negedge clk);
      note(3'h1, {20'h0, {12{c[1]}}});
      note(3'h2, {20'h0, {12{c[1] & c[0]}}});
      if (!c[1]) note(3'h3, {20'h0, ext ^ {12{c[0]}}});
    end
    mode = mppc_pkg::MODE_PARALLEL;
    repeat (2) @(negedge clk);
    note(3'h1, 32'h0000_0FFF);
    note(3'h2, 32'h0000_0FFE);
    wr_reg(8'h04, 32'h0000_0000);
    note(3'h1, 32'h0000_0001);
    mode = 2'h0;
    wr_reg(8'h10, 32'h0000_0100);
    ext = 12'h004;
    repeat (5) @(negedge clk);
    note(3'h4, 32'h0000_0001);
    rd_reg(8'h10, 32'h0000_0100);
    // Pin 2 set to drive high, so event mode must release it
    wr_reg(8'h04, 32'h0000_0030);
    wr_reg(8'h00, 32'h0000_0080);
    repeat (5) @(negedge clk);
    note(3'h1, 32'h0000_0000);
    note(3'h4, 32'h0000_0001);
    ext = 12'h000;
    repeat (5) @(negedge clk);
    note(3'h4, 32'h0000_0000);
    ext = 12'h004;
    repeat (5) @(negedge clk);
    rd_reg(8'h10, 32'h0000_8100);
    wr_reg(8'h10, 32'h0000_8100);
    note(3'h4, 32'h0000_0001);
    rd_reg(8'h00, 32'h0000_0080);
    rd_reg(8'h20, 32'h0000_0000);
    // Polarity bit cleared: pin 2 high is now the active level
    wr_reg(8'h04, 32'h0000_0000);
    repeat (2) @(negedge clk);
    note(3'h4, 32'h0000_0000);
    // Clear while the input stays active: the set must win
    wr_reg(8'h10, 32'h0000_8100);
    note(3'h4, 32'h0000_0000);
    rd_reg(8'h10, 32'h0000_8100);
    rst_b = 1'b0;
    @(negedge clk);
    note(3'h4, 32'h0000_0001);
    note(3'h1, 32'h0000_0000);
    note(3'h0, 32'h0000_0000);
    rst_b = 1'b1;
    rd_reg(8'h04, 32'h0000_0000);
    rd_reg(8'h10, 32'h0000_0000);
    @(negedge clk);
    conclude();
  end
endmodule : testbench
`default_nettype wire
